// file: rtl/sctp_pkg.sv
// sctp_pkg: constants, register indices, reset values and carrier types
// for the short-circuit and cell temperature protection block.
// assumes a 250 MHz reference clock and a 1 mOhm current shunt.
package sctp_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned DSC_LSB_NS = 20000;   // discharge filter step, 20 us
    localparam int unsigned CSC_LSB_NS = 200000;  // charge filter step, 200 us
    localparam int unsigned DSC_TICK_CYCLES = DSC_LSB_NS / CLK_PERIOD_NS;
    localparam int unsigned CSC_TICK_CYCLES = CSC_LSB_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [14:0] IDX_DSC_LEVEL = 15'h7fa2;
    localparam logic [14:0] IDX_DSC_TIME = 15'h7fa4;
    localparam logic [14:0] IDX_CSC_LEVEL = 15'h7fa5;
    localparam logic [14:0] IDX_CSC_TIME = 15'h7fa7;
    localparam logic [14:0] IDX_DIS_HOT = 15'h7fa8;
    localparam logic [14:0] IDX_CHG_HOT = 15'h7faa;
    localparam logic [14:0] IDX_DIS_COLD = 15'h7fac;
    localparam logic [14:0] IDX_CHG_COLD = 15'h7fae;
    localparam logic [14:0] IDX_HYST = 15'h7fb0;
    localparam logic [14:0] IDX_STATUS = 15'h7fe0;
    localparam logic [14:0] IDX_DSC_APPLIED = 15'h7fe1;
    localparam logic [14:0] IDX_CSC_APPLIED = 15'h7fe2;

    // ------------------------------------------------------------
    // reset values in register units
    // ------------------------------------------------------------
    localparam logic [15:0] RST_DSC_LEVEL = 16'h2bf2;  // 22500 mA
    localparam logic [6:0] RST_DSC_TIME = 7'h0a;       // 200 us
    localparam logic [15:0] RST_CSC_LEVEL = 16'h124f;  // 9374 mA
    localparam logic [6:0] RST_CSC_TIME = 7'h08;       // 1600 us
    localparam logic [15:0] RST_DIS_HOT = 16'h16a8;    // 58.00 C
    localparam logic [15:0] RST_CHG_HOT = 16'h10cc;    // 43.00 C
    localparam logic [15:0] RST_DIS_COLD = 16'hf8f8;   // -18.00 C
    localparam logic [15:0] RST_CHG_COLD = 16'h00c8;   // 2.00 C
    localparam logic [4:0] RST_HYST = 5'h02;

    // ------------------------------------------------------------
    // set point grids in 2 mA units
    // ------------------------------------------------------------
    localparam logic [17:0] DSC_FINE = 18'h0_0abe;    // 5.5 mV
    localparam logic [17:0] DSC_TOP = 18'h1_57c0;     // 176 mV, above any 16-bit level
    localparam logic [17:0] DSC_COARSE = 18'h0_203a;  // 16.5 mV
    localparam logic [17:0] DSC_MAX = 18'h0_f712;     // largest point in 16 bits
    localparam logic [17:0] CSC_FINE = 18'h0_04e2;    // 2.5 mV
    localparam logic [17:0] CSC_TOP = 18'h0_9c40;     // 80 mV
    localparam logic [17:0] CSC_COARSE = 18'h0_0ea6;  // 7.5 mV
    localparam logic [17:0] CSC_MAX = 18'h0_e57e;     // largest point up to 120 mV

    // hysteresis step in 0.01 C per field count
    localparam logic [17:0] HYST_STEP = 18'h0_0064;

    // status register bit positions
    localparam int unsigned ST_DSC = 0;
    localparam int unsigned ST_CSC = 1;
    localparam int unsigned ST_HOT = 2;
    localparam int unsigned ST_COLD = 3;
    localparam int unsigned ST_CHG = 4;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic signed [15:0] current;  // 2 mA lsb, positive while charging
        logic signed [15:0] temp;     // 0.01 C lsb
    } sctp_meas_t;

    typedef struct packed {
        logic cold;
        logic hot;
        logic charge_short;
        logic discharge_short;
    } sctp_fault_t;

    typedef struct packed {
        logic [15:0] dsc_level;
        logic [6:0] dsc_time;
        logic [15:0] csc_level;
        logic [6:0] csc_time;
        logic [15:0] dis_hot;
        logic [15:0] chg_hot;
        logic [15:0] dis_cold;
        logic [15:0] chg_cold;
        logic [4:0] hyst;
    } sctp_cfg_t;

endpackage : sctp_pkg

// file: rtl/sctp_protect.sv
// sctp_protect: register bank and trip logic for short-circuit and cell
// temperature protection, with an avalon-mm slave.
// assumes measurements synchronous to i_ref_clk and a 1 mOhm shunt.
//
// Notes on behaviour
// - discharge trip level: 16 bits, 2 mA lsb
// - discharge grid 5.5 mV only; the 16.5 mV step starts above any 16-bit level
// - discharge uses nearest grid point
// - discharge filter time: 7 bits, 20 us
// - discharge fault after filter time over level
// - charge trip level: 16 bits, 2 mA lsb
// - charge grid 2.5 mV, then 7.5 mV
// - charge uses nearest grid point
// - charge filter time: 7 bits, 200 us
// - discharge hot limit, signed, 0.01 C
// - charge hot limit, signed, 0.01 C
// - discharge cold limit, signed, 0.01 C
// - charge cold limit, signed, 0.01 C
// - one 5-bit hysteresis shared by hot/cold
//
// The Avalon-MM slave port is this design's own decision.

// ------------------------------------------------------------
// filter: counts time steps while a level stays exceeded
// ------------------------------------------------------------
module sctp_filter
    import sctp_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 5000
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_over,
    input wire logic [6:0] i_time,
    output logic o_trip
);
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
    logic [15:0] div;
    logic [15:0] next_div;
    logic [6:0] ticks;
    logic [6:0] next_ticks;

    // step counter restarts whenever the level drops back
    always_comb begin
        next_div = div;
        next_ticks = ticks;
        if (!i_over) begin
            next_div = 16'h0000;
            next_ticks = 7'h00;
        end else if (div == TICK_LAST) begin
            next_div = 16'h0000;
            if (ticks != 7'h7f) begin
                next_ticks = ticks + 7'h01;
            end
        end else begin
            next_div = div + 16'h0001;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            div <= 16'h0000;
            ticks <= 7'h00;
        end else begin
            div <= next_div;
            ticks <= next_ticks;
        end
    end

    // trip once the level held for the whole programmed time
    assign o_trip = i_over && (ticks >= i_time);
endmodule : sctp_filter

// ------------------------------------------------------------
// top: register bank, bus slave, set points and fault flags
// ------------------------------------------------------------
module sctp_protect
    import sctp_pkg::*;
#(
    parameter int unsigned DSC_TICK = DSC_TICK_CYCLES,
    parameter int unsigned CSC_TICK = CSC_TICK_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic [16:0] i_avm_address,
    input wire logic i_avm_read,
    input wire logic i_avm_write,
    input wire logic [31:0] i_avm_writedata,
    input wire logic [3:0] i_avm_byteenable,
    output logic [31:0] o_avm_readdata,
    output logic o_avm_waitrequest,
    input wire sctp_meas_t i_meas,
    output sctp_fault_t o_fault
);
    sctp_cfg_t cfg;
    sctp_cfg_t next_cfg;
    logic [31:0] next_rdata;
    logic next_wait;
    logic [31:0] rd_mux;
    logic [14:0] idx;
    logic take_wr;
    logic clr_dsc;
    logic clr_csc;
    logic [15:0] dsc_applied;
    logic [15:0] csc_applied;
    logic charging;
    logic over_dsc;
    logic over_csc;
    logic trip_dsc;
    logic trip_csc;
    logic [16:0] dis_mag;
    logic signed [17:0] t18;
    logic signed [17:0] hot18;
    logic signed [17:0] cold18;
    logic signed [17:0] hyst18;
    sctp_fault_t next_fault;

    // snap a level to the nearest point of a two-slope grid
    function automatic logic [15:0] sctp_snap(input logic [15:0] v, input logic [17:0] fine,
                                              input logic [17:0] top, input logic [17:0] coarse,
                                              input logic [17:0] maxc);
        logic [17:0] w;
        logic [17:0] q;
        w = {2'b00, v};
        if (w < top) begin
            q = 18'(((w + (fine >> 1)) / fine) * fine);
        end else begin
            q = 18'(top + ((w - top + (coarse >> 1)) / coarse) * coarse);
        end
        if (q > maxc) begin
            q = maxc;
        end
        return q[15:0];
    endfunction : sctp_snap

    // merge the two low byte lanes of a write
    function automatic logic [15:0] sctp_merge(input logic [15:0] old, input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : sctp_merge

    // ------------------------------------------------------------
    // applied set points
    // ------------------------------------------------------------
    assign dsc_applied = sctp_snap(cfg.dsc_level, DSC_FINE, DSC_TOP, DSC_COARSE, DSC_MAX);
    assign csc_applied = sctp_snap(cfg.csc_level, CSC_FINE, CSC_TOP, CSC_COARSE, CSC_MAX);

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    assign idx = i_avm_address[16:2];
    assign take_wr = i_avm_write && !o_avm_waitrequest;
    assign clr_dsc = take_wr && (idx == IDX_STATUS) && i_avm_byteenable[0] && i_avm_writedata[ST_DSC];
    assign clr_csc = take_wr && (idx == IDX_STATUS) && i_avm_byteenable[0] && i_avm_writedata[ST_CSC];

    // read multiplexer, unmapped words read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx)
            IDX_DSC_LEVEL: rd_mux[15:0] = cfg.dsc_level;
            IDX_DSC_TIME: rd_mux[6:0] = cfg.dsc_time;
            IDX_CSC_LEVEL: rd_mux[15:0] = cfg.csc_level;
            IDX_CSC_TIME: rd_mux[6:0] = cfg.csc_time;
            IDX_DIS_HOT: rd_mux[15:0] = cfg.dis_hot;
            IDX_CHG_HOT: rd_mux[15:0] = cfg.chg_hot;
            IDX_DIS_COLD: rd_mux[15:0] = cfg.dis_cold;
            IDX_CHG_COLD: rd_mux[15:0] = cfg.chg_cold;
            IDX_HYST: rd_mux[4:0] = cfg.hyst;
            IDX_STATUS: begin
                rd_mux[ST_DSC] = o_fault.discharge_short;
                rd_mux[ST_CSC] = o_fault.charge_short;
                rd_mux[ST_HOT] = o_fault.hot;
                rd_mux[ST_COLD] = o_fault.cold;
                rd_mux[ST_CHG] = charging;
            end
            IDX_DSC_APPLIED: rd_mux[15:0] = dsc_applied;
            IDX_CSC_APPLIED: rd_mux[15:0] = csc_applied;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // one wait cycle, then the request completes and writes take effect
    always_comb begin
        next_cfg = cfg;
        next_wait = 1'b1;
        next_rdata = o_avm_readdata;
        if ((i_avm_read || i_avm_write) && o_avm_waitrequest) begin
            next_wait = 1'b0;
            next_rdata = i_avm_read ? rd_mux : 32'h0000_0000;
        end
        if (take_wr) begin
            case (idx)
                IDX_DSC_LEVEL: next_cfg.dsc_level = sctp_merge(cfg.dsc_level, i_avm_writedata,
                                                               i_avm_byteenable);
                IDX_DSC_TIME: begin
                    if (i_avm_byteenable[0]) begin
                        next_cfg.dsc_time = i_avm_writedata[6:0];
                    end
                end
                IDX_CSC_LEVEL: next_cfg.csc_level = sctp_merge(cfg.csc_level, i_avm_writedata,
                                                               i_avm_byteenable);
                IDX_CSC_TIME: begin
                    if (i_avm_byteenable[0]) begin
                        next_cfg.csc_time = i_avm_writedata[6:0];
                    end
                end
                IDX_DIS_HOT: next_cfg.dis_hot = sctp_merge(cfg.dis_hot, i_avm_writedata,
                                                           i_avm_byteenable);
                IDX_CHG_HOT: next_cfg.chg_hot = sctp_merge(cfg.chg_hot, i_avm_writedata,
                                                           i_avm_byteenable);
                IDX_DIS_COLD: next_cfg.dis_cold = sctp_merge(cfg.dis_cold, i_avm_writedata,
                                                             i_avm_byteenable);
                IDX_CHG_COLD: next_cfg.chg_cold = sctp_merge(cfg.chg_cold, i_avm_writedata,
                                                             i_avm_byteenable);
                IDX_HYST: begin
                    if (i_avm_byteenable[0]) begin
                        next_cfg.hyst = i_avm_writedata[4:0];
                    end
                end
                default: next_cfg = cfg;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            cfg <= '{RST_DSC_LEVEL, RST_DSC_TIME, RST_CSC_LEVEL, RST_CSC_TIME, RST_DIS_HOT,
                     RST_CHG_HOT, RST_DIS_COLD, RST_CHG_COLD, RST_HYST};
            o_avm_waitrequest <= 1'b1;
            o_avm_readdata <= 32'h0000_0000;
        end else begin
            cfg <= next_cfg;
            o_avm_waitrequest <= next_wait;
            o_avm_readdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // short-circuit detection
    // ------------------------------------------------------------
    assign charging = (i_meas.current > 16'sh0000);
    assign dis_mag = 17'(-$signed({i_meas.current[15], i_meas.current}));
    assign over_dsc = i_meas.current[15] && (dis_mag > {1'b0, dsc_applied});
    assign over_csc = charging && ({1'b0, i_meas.current} > {1'b0, csc_applied});

    sctp_filter #(
        .TICK_CYCLES(DSC_TICK)
    ) u_dsc_filter (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_over(over_dsc),
        .i_time(cfg.dsc_time),
        .o_trip(trip_dsc)
    );

    sctp_filter #(
        .TICK_CYCLES(CSC_TICK)
    ) u_csc_filter (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_over(over_csc),
        .i_time(cfg.csc_time),
        .o_trip(trip_csc)
    );

    // ------------------------------------------------------------
    // temperature limits and fault flags
    // ------------------------------------------------------------
    assign t18 = {{2{i_meas.temp[15]}}, i_meas.temp};
    assign hot18 = charging ? {{2{cfg.chg_hot[15]}}, cfg.chg_hot} : {{2{cfg.dis_hot[15]}}, cfg.dis_hot};
    assign cold18 = charging ? {{2{cfg.chg_cold[15]}}, cfg.chg_cold}
                             : {{2{cfg.dis_cold[15]}}, cfg.dis_cold};
    assign hyst18 = $signed(18'({13'h0000, cfg.hyst} * HYST_STEP));

    // short faults are sticky until a write of one; a new trip beats the clear
    always_comb begin
        next_fault.discharge_short = trip_dsc || (o_fault.discharge_short && !clr_dsc);
        next_fault.charge_short = trip_csc || (o_fault.charge_short && !clr_csc);
        if (o_fault.hot) begin
            next_fault.hot = (t18 > (hot18 - hyst18));
        end else begin
            next_fault.hot = (t18 > hot18);
        end
        if (o_fault.cold) begin
            next_fault.cold = (t18 < (cold18 + hyst18));
        end else begin
            next_fault.cold = (t18 < cold18);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_fault <= '0;
        end else begin
            o_fault <= next_fault;
        end
    end
endmodule : sctp_protect

// file: test/sctp_afe_model.sv
// sctp_afe_model: behavioural front end for shunt current and cell temperature.
// assumes the bench sets the analog values; the codes appear one clock later.
// ------------------------------------------------------------
// front end
// ------------------------------------------------------------
module sctp_afe_model
    import sctp_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic [15:0] i_current,
    input wire logic [15:0] i_temp,
    output sctp_meas_t o_meas
);
    timeunit 1ns;
    timeprecision 1ns;
    // one conversion per clock, positive current while charging
    always_ff @(posedge i_ref_clk) begin
        o_meas <= '{current: i_current, temp: i_temp};
    end
endmodule : sctp_afe_model

// file: test/sctp_protect_sva.sv
// sctp_protect_sva: port-level checks of bus timing and fault flags.
// assumes it is bound onto sctp_protect with the same tick parameters.
// ------------------------------------------------------------
// checker
// ------------------------------------------------------------
module sctp_protect_sva
    import sctp_pkg::*;
#(
    parameter int unsigned DSC_TICK = 4,
    parameter int unsigned CSC_TICK = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic [16:0] i_avm_address,
    input wire logic i_avm_read,
    input wire logic i_avm_write,
    input wire logic [31:0] o_avm_readdata,
    input wire logic o_avm_waitrequest,
    input wire sctp_meas_t i_meas,
    input wire sctp_fault_t o_fault
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);
    // word index of the request on the bus
    logic [14:0] idx;
    assign idx = i_avm_address[16:2];
    // bus answer, field widths, fault causes, sticky discharge fault and steady temperature flags
    a_wait_one: assert property ((i_avm_read || i_avm_write) && o_avm_waitrequest |=> !o_avm_waitrequest)
        else $error("bus request not answered after one wait cycle");
    a_wait_pulse: assert property (!o_avm_waitrequest |=> o_avm_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_idle: assert property (!(i_avm_read || i_avm_write) && o_avm_waitrequest |=> o_avm_waitrequest)
        else $error("answer without a request");
    a_upper_zero: assert property (!o_avm_waitrequest |-> o_avm_readdata[31:16] == 16'h0000)
        else $error("read data above bit 15 not zero");
    a_time_width: assert property (!o_avm_waitrequest && i_avm_read && (idx == IDX_DSC_TIME || idx == IDX_CSC_TIME)
        |-> o_avm_readdata[31:7] == '0)
        else $error("filter time wider than 7 bits");
    a_hyst_width: assert property (!o_avm_waitrequest && i_avm_read && idx == IDX_HYST
        |-> o_avm_readdata[31:5] == '0)
        else $error("hysteresis wider than 5 bits");
    a_dsc_cause: assert property ($rose(o_fault.discharge_short) |-> $past(i_meas.current[15]))
        else $error("discharge fault without discharge current");
    a_csc_cause: assert property ($rose(o_fault.charge_short) |-> !$past(i_meas.current[15]) && $past(|i_meas.current))
        else $error("charge fault without charge current");
    a_dsc_sticky: assert property (o_fault.discharge_short && !(i_avm_write && !o_avm_waitrequest) |=> o_fault.discharge_short)
        else $error("discharge fault dropped without clear");
    a_temp_steady: assert property ($stable(i_meas) && $past($stable(i_meas)) && $past(i_rst_b) && $past(i_rst_b, 2)
        && $past(o_avm_waitrequest) && $past(o_avm_waitrequest, 2) |-> $stable({o_fault.hot, o_fault.cold}))
        else $error("temperature flag moved with steady input");
    // main scenarios reached
    c_write: cover property (i_avm_write && !o_avm_waitrequest);
    c_dsc: cover property ($rose(o_fault.discharge_short));
    c_csc: cover property ($rose(o_fault.charge_short));
    c_hot_clear: cover property ($fell(o_fault.hot));
endmodule : sctp_protect_sva

bind sctp_protect sctp_protect_sva #(.DSC_TICK(DSC_TICK), .CSC_TICK(CSC_TICK)) u_sva (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_avm_address(i_avm_address),
    .i_avm_read(i_avm_read), .i_avm_write(i_avm_write), .o_avm_readdata(o_avm_readdata),
    .o_avm_waitrequest(o_avm_waitrequest), .i_meas(i_meas), .o_fault(o_fault));

// file: test/sctp_protect_bench.sv
// sctp_protect_bench: register, set point, trip timing and temperature tests.
// assumes the front end model and the bound checker; short filter ticks.
// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module sctp_protect_bench
    import sctp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned DT = 4;
    localparam int unsigned CT = 8;
    logic ref_clk, rst_b, rd, wr, wait_req;
    logic [16:0] addr;
    logic [31:0] wdata, rdata, q;
    logic [3:0] be;
    logic [15:0] cur, temp;
    sctp_meas_t meas;
    sctp_fault_t fault;
    int num_errors, n_compared;
    logic [14:0] rix [9] = '{IDX_DSC_LEVEL, IDX_DSC_TIME, IDX_CSC_LEVEL, IDX_CSC_TIME, IDX_DIS_HOT,
        IDX_CHG_HOT, IDX_DIS_COLD, IDX_CHG_COLD, IDX_HYST};
    logic [31:0] rrst [9] = '{32'(RST_DSC_LEVEL), 32'(RST_DSC_TIME), 32'(RST_CSC_LEVEL), 32'(RST_CSC_TIME),
        32'(RST_DIS_HOT), 32'(RST_CHG_HOT), 32'(RST_DIS_COLD), 32'(RST_CHG_COLD), 32'(RST_HYST)};
    logic [31:0] rmsk [9] = '{32'h0000_ffff, 32'h0000_007f, 32'h0000_ffff, 32'h0000_007f, 32'h0000_ffff,
        32'h0000_ffff, 32'h0000_ffff, 32'h0000_ffff, 32'h0000_001f};
    logic [17:0] qv [7] = '{18'h0_055f, 18'h0_055e, 18'h0_bc7d, 18'h0_ffff, 18'h0_0271, 18'h0_a393, 18'h0_ffff};
    // nearest grid points for qv, worked out by hand in 2 mA units
    logic [15:0] qe [7] = '{16'h0abe, 16'h0000, 16'hc15c, 16'hf712, 16'h04e2, 16'haae6, 16'he57e};

    // clock
    always #2 ref_clk = ~ref_clk;

    sctp_afe_model i_afe (.i_ref_clk(ref_clk), .i_current(cur), .i_temp(temp), .o_meas(meas));
    sctp_protect #(.DSC_TICK(DT), .CSC_TICK(CT)) i_dut (
        .i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_avm_address(addr), .i_avm_read(rd), .i_avm_write(wr),
        .i_avm_writedata(wdata), .i_avm_byteenable(be), .o_avm_readdata(rdata),
        .o_avm_waitrequest(wait_req), .i_meas(meas), .o_fault(fault));

    // verdict and end of run
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR at %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [14:0] ix, input logic [31:0] d, input logic [3:0] b);
        int n;
        @(posedge ref_clk);
        rd <= !w;
        wr <= w;
        addr <= {ix, 2'b00};
        wdata <= d;
        be <= b;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wait_req !== 1'b0) begin
            num_errors++;
            test_done();
        end
    endtask : bus

    task automatic drive(input logic [15:0] c);
        @(posedge ref_clk);
        cur <= c;
    endtask : drive

    // counts edges until the fault bit shows, starting when the input is over
    task automatic trip(input int b, input int e);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (fault[b] !== 1'b1 && n < 2000);
        chk(32'(n), 32'(e));
        if (fault[b] !== 1'b1) begin
            test_done();
        end
    endtask : trip

    task automatic tstep(input logic [15:0] c, input logic [15:0] t, input logic [1:0] e);
        @(posedge ref_clk);
        cur <= c;
        temp <= t;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(32'({fault.cold, fault.hot}), 32'(e));
    endtask : tstep

    // main sequence
    initial begin
        ref_clk = 1'b0;
        rst_b = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = '0;
        wdata = '0;
        be = 4'hf;
        cur = 16'h0000;
        temp = 16'h09c4;
        num_errors = 0;
        n_compared = 0;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int k = 0; k < 9; k++) begin
            bus(1'b0, rix[k], 32'h0, 4'hf);
            chk(q, rrst[k]);
            bus(1'b1, rix[k], 32'hdead_beef, 4'hf);
            bus(1'b0, rix[k], 32'h0, 4'hf);
            chk(q, 32'hdead_beef & rmsk[k]);
            bus(1'b1, rix[k], rrst[k], 4'hf);
        end
        bus(1'b1, 15'h7fa3, 32'hffff_ffff, 4'hf);
        bus(1'b0, 15'h7fa3, 32'h0, 4'hf);
        chk(q, 32'h0000_0000);
        bus(1'b1, IDX_DSC_LEVEL, 32'h0000_ffff, 4'h1);
        bus(1'b0, IDX_DSC_LEVEL, 32'h0, 4'hf);
        chk(q, {16'h0000, RST_DSC_LEVEL[15:8], 8'hff});
        $display("registers done");
        for (int k = 0; k < 7; k++) begin
            bus(1'b1, (k < 4) ? IDX_DSC_LEVEL : IDX_CSC_LEVEL, 32'(qv[k]), 4'hf);
            bus(1'b0, (k < 4) ? IDX_DSC_APPLIED : IDX_CSC_APPLIED, 32'h0, 4'hf);
            chk(q, 32'(qe[k]));
        end
        $display("set points done");
        bus(1'b1, IDX_DSC_LEVEL, 32'(DSC_FINE), 4'hf);
        bus(1'b1, IDX_DSC_TIME, 32'h0000_0002, 4'hf);
        drive(16'hf448);
        repeat (5) @(posedge ref_clk);
        drive(16'h0000);
        drive(16'hf448);
        @(posedge ref_clk);
        trip(ST_DSC, 2 * DT + 1);
        drive(16'h0000);
        bus(1'b1, IDX_STATUS, 32'h0000_0001, 4'hf);
        bus(1'b0, IDX_STATUS, 32'h0, 4'hf);
        chk(q, 32'h0000_0000);
        $display("discharge trip done");
        bus(1'b1, IDX_CSC_LEVEL, 32'(CSC_FINE), 4'hf);
        bus(1'b1, IDX_CSC_TIME, 32'h0000_0001, 4'hf);
        drive(16'h0514);
        @(posedge ref_clk);
        trip(ST_CSC, CT + 1);
        bus(1'b0, IDX_STATUS, 32'h0, 4'hf);
        chk(q, 32'h0000_0012);
        drive(16'h0000);
        bus(1'b1, IDX_STATUS, 32'h0000_0002, 4'hf);
        bus(1'b0, IDX_STATUS, 32'h0, 4'hf);
        chk(q, 32'h0000_0000);
        $display("charge trip done");
        tstep(16'h0000, RST_DIS_HOT + 16'h0001, 2'b01);
        bus(1'b0, IDX_STATUS, 32'h0, 4'hf);
        chk(q, 32'h0000_0004);
        tstep(16'h0000, RST_DIS_HOT - 16'h0064, 2'b01);
        tstep(16'h0000, RST_DIS_HOT - 16'h00c8, 2'b00);
        tstep(16'h0064, RST_CHG_HOT + 16'h0064, 2'b01);
        tstep(16'h0000, RST_CHG_HOT + 16'h0064, 2'b00);
        tstep(16'h0000, RST_DIS_COLD - 16'h0001, 2'b10);
        tstep(16'h0000, RST_DIS_COLD + 16'h0064, 2'b10);
        tstep(16'h0000, RST_DIS_COLD + 16'h00c8, 2'b00);
        tstep(16'h0064, RST_CHG_COLD - 16'h0001, 2'b10);
        bus(1'b0, IDX_STATUS, 32'h0, 4'hf);
        chk(q, 32'h0000_0018);
        tstep(16'h0064, RST_CHG_COLD + 16'h00c8, 2'b00);
        bus(1'b1, IDX_HYST, 32'h0000_0001, 4'hf);
        tstep(16'h0000, RST_DIS_HOT + 16'h0001, 2'b01);
        tstep(16'h0000, RST_DIS_HOT - 16'h0064, 2'b00);
        $display("temperature done");
        test_done();
    end
endmodule : sctp_protect_bench
